// ===== rtl/pct_host.sv
/*
  host controller end: apb slave registers that drive the timer link.
  assumes an apb master on pclk; companion irq comes from user logic.
*/
`timescale 1ns/1ps
module pct_host (
  input  wire logic        pclk,      // 125 mhz clock
  input  wire logic        presetn,   // async reset, low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb write
  input  wire logic [11:0] paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error
  input  wire logic        comp_irq,  // companion counter pulse
  pct_if.host              lnk        // link to timer
);
  import pct_pkg::*;

  logic [1:0] ctrl_ff;
  logic [7:0] per_ff;
  logic [7:0] duty_ff;
  logic [1:0] gate_ff;
  logic       dwr_ff;
  logic       swr_ff;
  logic       seen_irq_ff;
  logic       wr;
  logic       rd;
  logic       hit;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign hit = (paddr == PCT_OFF_CTRL) || (paddr == PCT_OFF_PERIOD) ||
               (paddr == PCT_OFF_DUTY) || (paddr == PCT_OFF_GATE) ||
               (paddr == PCT_OFF_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 2'h0;
      per_ff  <= PCT_CMP_RST;
      duty_ff <= PCT_CMP_RST;
      gate_ff <= 2'h0;
      dwr_ff  <= 1'b0;
      swr_ff  <= 1'b0;
    end else begin
      dwr_ff <= 1'b0;
      swr_ff <= 1'b0;
      if (wr) begin
        case (paddr)
          PCT_OFF_CTRL:   ctrl_ff <= pwdata[1:0];
          PCT_OFF_PERIOD: per_ff  <= pwdata[7:0];
          PCT_OFF_DUTY: begin
            duty_ff <= pwdata[7:0];
            dwr_ff  <= 1'b1;
          end
          PCT_OFF_GATE: begin
            gate_ff <= pwdata[1:0];
            swr_ff  <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // sticky: a new transfer beats a simultaneous status clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_irq_ff <= 1'b0;
    end else if (lnk.sync_transfer_pulse) begin
      seen_irq_ff <= 1'b1;
    end else if (wr && paddr == PCT_OFF_STATUS && pwdata[2]) begin
      seen_irq_ff <= 1'b0;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      PCT_OFF_CTRL:   prdata = {30'h0, ctrl_ff};
      PCT_OFF_PERIOD: prdata = {24'h0, per_ff};
      PCT_OFF_DUTY:   prdata = {24'h0, duty_ff};
      PCT_OFF_GATE:   prdata = {29'h0, lnk.gate_active_bit, gate_ff};
      PCT_OFF_STATUS: prdata = {29'h0, seen_irq_ff, lnk.carrier_out_pin,
                                lnk.pulse_out};
      default:        prdata = 32'h0000_0000;
    endcase
    if (!rd) begin
      prdata = 32'h0000_0000;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  assign lnk.run_enable           = ctrl_ff[PCT_CTRL_RUN];
  assign lnk.carrier_mode         = ctrl_ff[PCT_CTRL_MODE];
  assign lnk.period_compare       = per_ff;
  assign lnk.duty_compare         = duty_ff;
  assign lnk.duty_wr              = dwr_ff;
  assign lnk.gate_staging_bit     = gate_ff[PCT_GATE_STAGE];
  assign lnk.stage_wr             = swr_ff;
  assign lnk.remote_output_enable = gate_ff[PCT_GATE_REMOTE];
  assign lnk.companion_irq        = comp_irq;
endmodule

// ===== rtl/pct_if.sv
/*
  link between the timer device and its host controller.
  assumes both ends share pclk and presetn.
*/
`timescale 1ns/1ps
interface pct_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic       run_enable;        // counting on
  logic       carrier_mode;      // carrier generator selected
  logic [7:0] period_compare;    // period or low width
  logic [7:0] duty_compare;      // duty or high width
  logic       duty_wr;           // pulse: duty register written
  logic       gate_staging_bit;  // staging gate value
  logic       stage_wr;          // pulse: staging bit written
  logic       remote_output_enable;
  logic       companion_irq;     // pulse from companion counter
  logic       gate_active_bit;   // read-only active gate
  logic       sync_transfer_pulse;
  logic       match_irq;
  logic       pulse_out;
  logic       carrier_out_pin;

  modport device (
    input  run_enable, carrier_mode, period_compare, duty_compare, duty_wr,
           gate_staging_bit, stage_wr, remote_output_enable, companion_irq,
    output gate_active_bit, sync_transfer_pulse, match_irq, pulse_out,
           carrier_out_pin
  );
  modport host (
    output run_enable, carrier_mode, period_compare, duty_compare, duty_wr,
           gate_staging_bit, stage_wr, remote_output_enable, companion_irq,
    input  gate_active_bit, sync_transfer_pulse, match_irq, pulse_out,
           carrier_out_pin
  );
endinterface

// ===== rtl/pct_pkg.sv
/*
  package for the pwm / carrier timer: mode codes, reset values, timing
  constants and apb register offsets shared by both ends.
  assumes a single 125 mhz pclk domain and an apb master on the host side.
*/
package pct_pkg;
  typedef enum logic [1:0] {
    PCT_MODE_PWM     = 2'h0,
    PCT_MODE_CARRIER = 2'h1
  } pct_mode_t;

  localparam logic [7:0]  PCT_CMP_RST      = 8'h00;
  localparam logic [1:0]  PCT_DUTY_SETTLE  = 2'h3;  // count clocks
  localparam int          PCT_CNT_DIV      = 4;     // pclk per count clock
  // apb register byte offsets
  localparam logic [11:0] PCT_OFF_CTRL     = 12'h000;
  localparam logic [11:0] PCT_OFF_PERIOD   = 12'h004;
  localparam logic [11:0] PCT_OFF_DUTY     = 12'h008;
  localparam logic [11:0] PCT_OFF_GATE     = 12'h00c;
  localparam logic [11:0] PCT_OFF_STATUS   = 12'h010;
  // ctrl and gate register field positions
  localparam int          PCT_CTRL_RUN     = 0;
  localparam int          PCT_CTRL_MODE    = 1;
  localparam int          PCT_GATE_STAGE   = 0;
  localparam int          PCT_GATE_REMOTE  = 1;
endpackage

// ===== rtl/pct_timer.sv
/*
  8-bit compare timer end: pwm mode, and carrier mode when CARRIER_OK.
  assumes the host keeps compare values legal and the companion irq is
  a pclk-domain pulse; count clock is a divided enable of pclk.
*/
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module pct_timer #(
  parameter bit CARRIER_OK = 1'b1  // second instance only
) (
  input wire logic pclk,     // 125 mhz clock
  input wire logic presetn,  // async reset, low
  pct_if.device    lnk       // link to host
);
  import pct_pkg::*;

  logic [1:0] div_ff;
  logic       tick;
  logic       run_q_ff;
  logic [7:0] cnt_ff;
  // one-hot compare selector
  typedef enum logic [1:0] {
    CMP_FIRST  = 2'b01,      // period, or carrier low width
    CMP_SECOND = 2'b10       // duty, or carrier high width
  } pct_cmp_t;
  pct_cmp_t   cmp_sel_ff;
  logic       sel_duty;
  logic       wave_ff;
  logic       irq_ff;
  logic [7:0] duty_act_ff;
  logic [7:0] duty_lat_ff;
  logic       lat_pend_ff;
  logic [1:0] age_ff;
  logic [1:0] sync_ff;       // companion irq stretched to count clock
  logic       xfer_ff;
  logic [1:0] xfer_dly_ff;
  logic       active_ff;
  logic       hold_ff;
  logic       carr;
  logic       started;
  logic       match;

  assign carr    = CARRIER_OK && lnk.carrier_mode;
  assign started = lnk.run_enable && run_q_ff;
  assign sel_duty = (cmp_sel_ff == CMP_SECOND);
  assign match   = tick && started &&
                   (cnt_ff == (sel_duty ? duty_act_ff
                                        : lnk.period_compare));

  // a match that ends a whole period clears the counter and raises irq
  function automatic logic ends_period(input logic second, input logic car);
    return !second || car;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign tick = (div_ff == 2'(PCT_CNT_DIV - 1));

  // first count clock after enable is swallowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q_ff <= 1'b0;
    end else if (!lnk.run_enable) begin
      run_q_ff <= 1'b0;
    end else if (tick) begin
      run_q_ff <= 1'b1;
    end
  end

  // counter: cleared on stop and on every match that ends a period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
    end else if (!lnk.run_enable) begin
      cnt_ff <= 8'h00;
    end else if (match && ends_period(sel_duty, carr)) begin
      cnt_ff <= 8'h00;
    end else if (tick && started) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // output toggles on every match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_ff <= 1'b0;
    end else if (!lnk.run_enable) begin
      wave_ff <= 1'b0;
    end else if (match) begin
      wave_ff <= ~wave_ff;
    end
  end

  // a pwm duty match toggles the output but raises no irq;
  // a stop clears it too, since match needs the run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= match && ends_period(sel_duty, carr);
    end
  end

  // compare register alternates at each match; a stop restarts at first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_sel_ff <= CMP_FIRST;
    end else if (!lnk.run_enable) begin
      cmp_sel_ff <= CMP_FIRST;
    end else if (match) begin
      case (cmp_sel_ff)
        CMP_FIRST:  cmp_sel_ff <= CMP_SECOND;
        CMP_SECOND: cmp_sel_ff <= CMP_FIRST;
        default:    cmp_sel_ff <= CMP_FIRST;
      endcase
    end
  end

  // duty latch: transfer only at an old-value match, after settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_act_ff <= PCT_CMP_RST;
      duty_lat_ff <= PCT_CMP_RST;
      lat_pend_ff <= 1'b0;
      age_ff      <= 2'h0;
    end else if (lnk.duty_wr) begin
      duty_lat_ff <= lnk.duty_compare;
      age_ff      <= 2'h0;
      if (!lnk.run_enable) begin
        duty_act_ff <= lnk.duty_compare;  // stopped: load at once
        lat_pend_ff <= 1'b0;
      end else begin
        lat_pend_ff <= 1'b1;
      end
    end else begin
      if (tick && age_ff != PCT_DUTY_SETTLE) begin
        age_ff <= age_ff + 2'h1;
      end
      if (match && sel_duty && lat_pend_ff &&
          age_ff == PCT_DUTY_SETTLE) begin
        duty_act_ff <= duty_lat_ff;
        lat_pend_ff <= 1'b0;
      end
    end
  end

  // companion irq held until the next count clock, then edge-detected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff     <= 2'h0;
      xfer_ff     <= 1'b0;
      xfer_dly_ff <= 2'h0;
    end else begin
      if (lnk.companion_irq) begin
        sync_ff[0] <= 1'b1;
      end else if (tick) begin
        sync_ff[0] <= 1'b0;
      end
      xfer_ff <= 1'b0;
      if (tick) begin
        sync_ff[1]  <= sync_ff[0];
        xfer_ff     <= sync_ff[0] && !sync_ff[1];
        xfer_dly_ff <= {xfer_dly_ff[0], xfer_ff};
      end else if (xfer_ff) begin
        xfer_dly_ff[0] <= 1'b1;
      end
    end
  end

  // active gate loads on the second count clock after the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= 1'b0;
    end else if (tick && xfer_dly_ff[1] && carr) begin
      active_ff <= lnk.gate_staging_bit;
    end
  end

  // keep the pin high through a running carrier high phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b0;
    end else if (!wave_ff) begin
      hold_ff <= 1'b0;
    end else if (active_ff) begin
      hold_ff <= 1'b1;
    end
  end

  always_comb begin
    if (!lnk.gate_staging_bit && !active_ff && !hold_ff) begin
      lnk.carrier_out_pin = 1'b0;
    end else if (!lnk.remote_output_enable) begin
      lnk.carrier_out_pin = active_ff;
    end else begin
      lnk.carrier_out_pin = wave_ff && (active_ff || hold_ff);
    end
  end

  assign lnk.gate_active_bit     = active_ff;
  assign lnk.sync_transfer_pulse = xfer_ff;
  assign lnk.match_irq           = irq_ff;
  assign lnk.pulse_out           = wave_ff & ~carr;
endmodule

// ===== sim/pct_link_sva.sv
/* link checker for the pwm / carrier timer.
   assumes one pclk domain; instantiated beside the link. */
`timescale 1ns/1ps
module pct_link_sva
  import pct_pkg::*;
(
  input wire logic       pclk,                 // clock
  input wire logic       presetn,              // reset, low
  input wire logic       run_enable,           // run
  input wire logic       carrier_mode,         // mode
  input wire logic [7:0] period_compare,       // low width
  input wire logic [7:0] duty_compare,         // high width
  input wire logic       gate_staging_bit,     // stage
  input wire logic       remote_output_enable, // remote
  input wire logic       companion_irq,        // companion
  input wire logic       gate_active_bit,      // active
  input wire logic       sync_transfer_pulse,  // transfer
  input wire logic       match_irq,            // irq
  input wire logic       pulse_out,            // pwm out
  input wire logic       carrier_out_pin       // pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [11:0] gap_ff;   // pclk since the last irq
  logic        seen_ff;  // first interval of a run has no start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_ff <= 12'h001;
    else if (match_irq || !run_enable) gap_ff <= 12'h001;
    else gap_ff <= gap_ff + 12'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_ff <= 1'b0;
    else seen_ff <= run_enable && (seen_ff || match_irq);
  end
  function automatic logic [11:0] len(input logic [7:0] v);
    return 12'(({4'h0, v} + 12'h001) * PCT_CNT_DIV);
  endfunction
  sequence s_sync;
    ##[1:5] sync_transfer_pulse;
  endsequence
  sequence s_load;
    ##[3:10] (gate_active_bit == gate_staging_bit);
  endsequence
  stop_quiet_a: assert property (
    !run_enable |=> !match_irq && !pulse_out)
    else $error("output active while stopped");
  start_mask_a: assert property (
    $rose(run_enable) |-> (!pulse_out && !match_irq) [*4])
    else $error("output moved before first match");
  period_edge_a: assert property (
    match_irq && !carrier_mode |-> $rose(pulse_out))
    else $error("period match did not raise output");
  duty_edge_a: assert property (
    $fell(pulse_out) && run_enable |-> !match_irq)
    else $error("irq on duty match");
  pwm_len_a: assert property (
    match_irq && seen_ff && !carrier_mode
      |-> gap_ff == len(period_compare))
    else $error("pwm cycle length wrong");
  carrier_len_a: assert property (
    match_irq && seen_ff && carrier_mode
      |-> gap_ff == len(period_compare) || gap_ff == len(duty_compare))
    else $error("carrier width wrong");
  sync_pulse_a: assert property (companion_irq |-> s_sync)
    else $error("no transfer pulse");
  gate_load_a: assert property (sync_transfer_pulse |-> s_load)
    else $error("active bit not loaded");
  pin_low_a: assert property (
    !gate_staging_bit && !gate_active_bit && !carrier_out_pin
      |=> !carrier_out_pin)
    else $error("pin not low");
  gate_hold_a: assert property (
    $fell(gate_active_bit) && $past(carrier_out_pin) && remote_output_enable
      |-> carrier_out_pin || match_irq)
    else $error("carrier high phase cut short");
  pin_high_a: assert property (
    !remote_output_enable && gate_active_bit |-> carrier_out_pin)
    else $error("pin not high");
endmodule

// ===== sim/pwm_carrier_timer_test.sv
/* bench: apb host end and timer end joined by the link.
   assumes 125 mhz pclk and the host register map. */
`timescale 1ns/1ps
module pwm_carrier_timer_test;
  import pct_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        comp_irq = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          comparisons = 0;
  always #4 pclk = ~pclk;
  pct_if lnk (.pclk(pclk), .presetn(presetn));
  pct_timer u_pct_timer (.pclk(pclk), .presetn(presetn), .lnk(lnk));
  pct_host u_pct_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_irq(comp_irq), .lnk(lnk));
  pct_link_sva u_pct_link_sva (.pclk(pclk), .presetn(presetn),
    .run_enable(lnk.run_enable), .carrier_mode(lnk.carrier_mode),
    .period_compare(lnk.period_compare),
    .duty_compare(lnk.duty_compare),
    .gate_staging_bit(lnk.gate_staging_bit),
    .remote_output_enable(lnk.remote_output_enable),
    .companion_irq(lnk.companion_irq),
    .gate_active_bit(lnk.gate_active_bit),
    .sync_transfer_pulse(lnk.sync_transfer_pulse),
    .match_irq(lnk.match_irq), .pulse_out(lnk.pulse_out),
    .carrier_out_pin(lnk.carrier_out_pin));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic lvl(input bit c);
    return c ? lnk.carrier_out_pin : lnk.pulse_out;
  endfunction
  // sampled on the falling edge, where the outputs have settled
  task automatic cnt(input bit c, input logic v, output int n);
    n = 0;
    while (lvl(c) === v && n < 3000) begin
      n++;
      @(negedge pclk);
    end
  endtask
  task automatic wave(input bit c, output int h, output int l);
    @(negedge pclk);
    cnt(c, 1'b0, l);
    cnt(c, 1'b1, h);
    cnt(c, 1'b0, l);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h0ff, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_pwm(input logic [7:0] n, input logic [7:0] m);
    int h;
    int l;
    apb(1'b1, PCT_OFF_PERIOD, {24'h0, n});
    apb(1'b1, PCT_OFF_DUTY, {24'h0, m});
    apb(1'b1, PCT_OFF_CTRL, 32'h1);
    wave(1'b0, h, l);
    chk("pwm high", (m + 1) * PCT_CNT_DIV, h);
    chk("pwm cycle", (n + 1) * PCT_CNT_DIV, h + l);
    apb(1'b1, PCT_OFF_CTRL, 32'h0);
    apb(1'b0, PCT_OFF_STATUS, 32'h0);
    chk("stopped out", 32'h0, rd & 32'h1);
  endtask
  task automatic t_duty();
    int h;
    int l;
    apb(1'b1, PCT_OFF_PERIOD, 32'h9);
    apb(1'b1, PCT_OFF_DUTY, 32'h1);
    apb(1'b1, PCT_OFF_CTRL, 32'h1);
    @(negedge pclk);
    cnt(1'b0, 1'b0, h);
    apb(1'b1, PCT_OFF_DUTY, 32'h5);
    @(negedge pclk);
    cnt(1'b0, 1'b1, h);
    chk("old duty kept", 32'h1, {31'h0, h < 8});
    wave(1'b0, h, l);
    cnt(1'b0, 1'b1, h);
    chk("new duty", (5 + 1) * PCT_CNT_DIV, h);
    apb(1'b1, PCT_OFF_CTRL, 32'h0);
  endtask
  // companion pulses stay far apart, well below the count clock rate
  task automatic xfer(input logic [31:0] g);
    @(posedge pclk);
    comp_irq <= 1'b1;
    @(posedge pclk);
    comp_irq <= 1'b0;
    repeat (16) @(posedge pclk);
    apb(1'b0, PCT_OFF_GATE, 32'h0);
    chk("gate active", g, rd);
    apb(1'b0, PCT_OFF_STATUS, 32'h0);
    chk("transfer seen", 32'h4, rd & 32'h4);
    apb(1'b1, PCT_OFF_STATUS, 32'h4);
  endtask
  task automatic t_carrier();
    int h;
    int l;
    apb(1'b1, PCT_OFF_PERIOD, 32'h3);
    apb(1'b1, PCT_OFF_DUTY, 32'h1);
    apb(1'b1, PCT_OFF_GATE, 32'h7);
    apb(1'b0, PCT_OFF_GATE, 32'h0);
    chk("active read only", 32'h3, rd);
    apb(1'b1, PCT_OFF_CTRL, 32'h3);
    xfer(32'h7);
    wave(1'b1, h, l);
    chk("carrier high", (1 + 1) * PCT_CNT_DIV, h);
    chk("carrier low", (3 + 1) * PCT_CNT_DIV, l);
    apb(1'b1, PCT_OFF_GATE, 32'h2);
    xfer(32'h2);
    apb(1'b0, PCT_OFF_STATUS, 32'h0);
    chk("pin gated off", 32'h0, rd & 32'h2);
    apb(1'b1, PCT_OFF_GATE, 32'h1);
    xfer(32'h5);
    apb(1'b0, PCT_OFF_STATUS, 32'h0);
    chk("pin held high", 32'h2, rd & 32'h2);
    apb(1'b1, PCT_OFF_CTRL, 32'h0);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pwm(8'h05, 8'h02);
    t_pwm(8'h01, 8'h00);
    t_pwm(8'hff, 8'hfe);
    t_pwm(8'hff, 8'h00);
    t_duty();
    t_carrier();
    results();
  end
endmodule
